// ==== include/cpm_pkg.sv ====
/*
 * Constants and types shared by the clock and power-mode controller.
 * Assumes a single 25 MHz system clock that samples all oscillator levels.
 */
package cpm_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned WAKE_US = 35;
   // Longest time rounds down: 875 cycles at 25 MHz
   localparam int unsigned WAKE_CYC = (WAKE_US * (CLK_HZ / 1_000_000));

   // ------------------------------------------------------------
   // Clock sources
   // ------------------------------------------------------------
   localparam int unsigned NUM_SRC = 4;
   localparam logic [1:0] SRC_MAIN = 2'h0;
   localparam logic [1:0] SRC_LF = 2'h1;
   localparam logic [1:0] SRC_WATCH = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h3;
   localparam logic [1:0] SRC_RESET = SRC_MAIN;

   // ------------------------------------------------------------
   // Main oscillator trim: 24 MHz + 4 MHz per step, up to 48 MHz
   // ------------------------------------------------------------
   localparam int unsigned MAIN_BASE_MHZ = 24;
   localparam int unsigned MAIN_STEP_MHZ = 4;
   localparam logic [2:0] TRIM_RESET = 3'h0;
   localparam logic [2:0] TRIM_MAX = 3'h6;

   // ------------------------------------------------------------
   // Peripheral dividers
   // ------------------------------------------------------------
   localparam int unsigned NUM_DIV = 8;
   localparam int unsigned NUM_FRAC = 2;
   localparam int unsigned DIV_W = 16;
   localparam int unsigned FRAC_W = 5;
   localparam int unsigned NUM_IRQ = 8;

   // ------------------------------------------------------------
   // Power modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CPM_ACTIVE = 2'h0,
      CPM_SLEEP = 2'h1,
      CPM_DEEP = 2'h3,
      CPM_HFWAKE = 2'h2
   } cpm_mode_t;

endpackage

// ==== include/cpm_div_if.sv ====
/*
 * Link between the mode controller and one peripheral divider.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface cpm_div_if;
   import cpm_pkg::*;
   logic root_rise;
   logic run;
   logic en;
   logic [DIV_W-1:0] div_val;
   logic [FRAC_W-1:0] frac;
   logic tick;
   modport ctl(output root_rise, run, en, div_val, frac, input tick);
   modport div(input root_rise, run, en, div_val, frac, output tick);
endinterface

// ==== src/cpm_divider.sv ====
/*
 * One 16-bit peripheral clock divider, integer or fractional.
 * Assumes root_rise is a one-cycle pulse per root clock rising edge.
 */
`timescale 1ns/1ps
module cpm_divider
   import cpm_pkg::*;
#(
   parameter bit FRAC = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   cpm_div_if.div d
);

   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] nxt_cnt;
   logic [FRAC_W-1:0] acc_ff;
   logic [FRAC_W-1:0] nxt_acc;
   logic extra_ff;
   logic nxt_extra;
   logic tick_ff;
   logic nxt_tick;
   logic [FRAC_W:0] sum;
   logic term;

   // ------------------------------------------------------------
   // Counting: period is div_val+1 root edges, plus one on carry
   // ------------------------------------------------------------
   always_comb begin
      sum = {1'b0, acc_ff} + {1'b0, (FRAC ? d.frac : {FRAC_W{1'b0}})};
      term = ({1'b0, cnt_ff} ==
              ({1'b0, d.div_val} + {{DIV_W{1'b0}}, extra_ff}));
      nxt_cnt = cnt_ff;
      nxt_acc = acc_ff;
      nxt_extra = extra_ff;
      nxt_tick = 1'b0;
      if (!d.run || !d.en) begin
         nxt_cnt = '0;
         nxt_acc = '0;
         nxt_extra = 1'b0;
      end else if (d.root_rise) begin
         if (term) begin
            nxt_cnt = '0;
            nxt_tick = 1'b1;
            nxt_acc = sum[FRAC_W-1:0];
            nxt_extra = sum[FRAC_W];
         end else begin
            nxt_cnt = cnt_ff + 16'h0001;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cnt_ff <= '0;
         acc_ff <= '0;
         extra_ff <= 1'b0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         acc_ff <= nxt_acc;
         extra_ff <= nxt_extra;
         tick_ff <= nxt_tick;
      end
   end

   assign d.tick = tick_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_tick_from_edge: assert property (@(posedge i_clk)
      disable iff (!i_rstn) d.tick |-> $past(d.root_rise) && $past(d.run))
      else $error("divider ticked without a root edge");
   a_idle_no_tick: assert property (@(posedge i_clk)
      disable iff (!i_rstn) (!d.run || !d.en) |=> !d.tick)
      else $error("stopped divider produced a tick");

endmodule

// ==== src/cpm_top.sv ====
/*
 * Clock source selection, power-mode clock gating and eight peripheral
 * dividers. Assumes all oscillator and request inputs are levels sampled
 * on I_CLK, which runs faster than any selected source.
 */
`timescale 1ns/1ps
module cpm_top
   import cpm_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_MAIN_OSC,
   input wire logic I_LF_OSC,
   input wire logic I_WATCH_OSC,
   input wire logic I_EXT_CLK,
   input wire logic [1:0] I_SRC_SEL,
   input wire logic [2:0] I_TRIM_SEL,
   input wire logic I_SLEEP_REQ,
   input wire logic I_DEEP_REQ,
   input wire logic [NUM_IRQ-1:0] I_IRQ,
   input wire logic [NUM_IRQ-1:0] I_IRQ_EN,
   input wire logic [NUM_DIV-1:0] I_DIV_EN,
   input wire logic [NUM_DIV*DIV_W-1:0] I_DIV_VAL,
   input wire logic [NUM_FRAC*FRAC_W-1:0] I_DIV_FRAC,
   output logic O_ROOT_CLK,
   output logic O_CPU_CLK_EN,
   output logic O_FLASH_CLK_EN,
   output logic O_SRAM_CLK_EN,
   output logic O_PERI_CLK_EN,
   output logic O_HF_EN,
   output logic O_LF_CLK,
   output logic O_WDT_CLK,
   output logic [2:0] O_TRIM,
   output logic [1:0] O_MODE,
   output logic O_WAKE,
   output logic [1:0] O_CUR_SRC,
   output logic O_SWITCHING,
   output logic [NUM_DIV-1:0] O_DIV_TICK
);

   localparam int A_WAKE_LIM = WAKE_CYC + 1;

   // Picks one synchronised source level
   function automatic logic src_pick(input logic [NUM_SRC-1:0] lv,
                                     input logic [1:0] sel);
      src_pick = lv[sel];
   endfunction

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic [5:0] nxt_sync1;
   logic [NUM_SRC-1:0] src_lv;
   logic [1:0] sel_req;

   // First stage feeds only the second stage
   always_comb begin
      nxt_sync1 = {I_SRC_SEL, I_EXT_CLK, I_WATCH_OSC, I_LF_OSC, I_MAIN_OSC};
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         sync1_ff <= 6'h00;
         sync2_ff <= 6'h00;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= sync1_ff;
      end
   end

   assign src_lv = sync2_ff[3:0];
   assign sel_req = sync2_ff[5:4];

   // ------------------------------------------------------------
   // Power mode sequencer
   // ------------------------------------------------------------
   cpm_mode_t mode_ff;
   cpm_mode_t nxt_mode;
   logic [9:0] wcnt_ff;
   logic [9:0] nxt_wcnt;
   logic cpu_en_ff;
   logic peri_en_ff;
   logic hf_en_ff;
   logic wake_ff;
   logic nxt_cpu_en;
   logic nxt_peri_en;
   logic nxt_hf_en;
   logic nxt_wake;
   logic wake_evt;

   // Interrupt unit is plain logic, so it keeps working with CPU off
   assign wake_evt = |(I_IRQ & I_IRQ_EN);

   always_comb begin
      nxt_mode = mode_ff;
      nxt_wcnt = 10'h000;
      nxt_wake = 1'b0;
      unique case (mode_ff)
         CPM_ACTIVE: begin
            if (I_DEEP_REQ) begin
               nxt_mode = CPM_DEEP;
            end else if (I_SLEEP_REQ) begin
               nxt_mode = CPM_SLEEP;
            end
         end
         CPM_SLEEP: begin
            if (wake_evt) begin
               nxt_mode = CPM_ACTIVE;
               nxt_wake = 1'b1;
            end
         end
         CPM_DEEP: begin
            if (wake_evt) begin
               nxt_mode = CPM_HFWAKE;
               nxt_wake = 1'b1;
            end
         end
         CPM_HFWAKE: begin
            // Give up waiting at the deadline rather than miss it
            nxt_wcnt = wcnt_ff + 10'h001;
            if (src_lv[SRC_MAIN] ||
                ({22'h00_0000, wcnt_ff} == WAKE_CYC - 2)) begin
               nxt_mode = CPM_ACTIVE;
            end
         end
      endcase
      nxt_cpu_en = (nxt_mode == CPM_ACTIVE);
      nxt_peri_en = (nxt_mode == CPM_ACTIVE) || (nxt_mode == CPM_SLEEP);
      nxt_hf_en = (nxt_mode != CPM_DEEP);
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         mode_ff <= CPM_ACTIVE;
         wcnt_ff <= 10'h000;
         cpu_en_ff <= 1'b1;
         peri_en_ff <= 1'b1;
         hf_en_ff <= 1'b1;
         wake_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         wcnt_ff <= nxt_wcnt;
         cpu_en_ff <= nxt_cpu_en;
         peri_en_ff <= nxt_peri_en;
         hf_en_ff <= nxt_hf_en;
         wake_ff <= nxt_wake;
      end
   end

   // ------------------------------------------------------------
   // Glitch-free root clock selection
   // ------------------------------------------------------------
   logic [1:0] cur_ff;
   logic [1:0] nxt_cur;
   logic busy_ff;
   logic nxt_busy;
   logic gate_ff;
   logic nxt_gate;
   logic root_ff;
   logic nxt_root;
   logic root_d_ff;
   logic [2:0] trim_ff;
   logic [2:0] nxt_trim;
   logic cur_lv;
   logic hf_off;

   assign cur_lv = src_pick(src_lv, cur_ff);
   assign hf_off = !hf_en_ff && (cur_ff == SRC_MAIN);

   // Output is only frozen or released while the level is low, so a
   // changeover just stretches a low phase. Costs up to two periods.
   always_comb begin
      nxt_cur = cur_ff;
      nxt_busy = busy_ff;
      nxt_gate = cur_lv ? gate_ff : hf_off;
      if (!busy_ff) begin
         if ((sel_req != cur_ff) && !cur_lv && !root_ff) begin
            nxt_busy = 1'b1;
         end
      end else if (!src_pick(src_lv, sel_req)) begin
         nxt_cur = sel_req;
         nxt_busy = 1'b0;
      end
      nxt_root = (busy_ff || gate_ff) ? 1'b0 : cur_lv;
      nxt_trim = (I_TRIM_SEL > TRIM_MAX) ? TRIM_MAX : I_TRIM_SEL;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         cur_ff <= SRC_RESET;
         busy_ff <= 1'b0;
         gate_ff <= 1'b0;
         root_ff <= 1'b0;
         root_d_ff <= 1'b0;
         trim_ff <= TRIM_RESET;
      end else begin
         cur_ff <= nxt_cur;
         busy_ff <= nxt_busy;
         gate_ff <= nxt_gate;
         root_ff <= nxt_root;
         root_d_ff <= root_ff;
         trim_ff <= nxt_trim;
      end
   end

   // ------------------------------------------------------------
   // Peripheral dividers
   // ------------------------------------------------------------
   cpm_div_if div_if[NUM_DIV]();

   for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
      assign div_if[g].root_rise = root_ff && !root_d_ff;
      assign div_if[g].run = peri_en_ff;
      assign div_if[g].en = I_DIV_EN[g];
      assign div_if[g].div_val = I_DIV_VAL[g*DIV_W +: DIV_W];
      if (g < NUM_FRAC) begin : g_frac
         assign div_if[g].frac = I_DIV_FRAC[g*FRAC_W +: FRAC_W];
      end else begin : g_int
         assign div_if[g].frac = '0;
      end
      assign O_DIV_TICK[g] = div_if[g].tick;
      cpm_divider #(.FRAC(g < NUM_FRAC)) u_div (
         .i_clk(I_CLK),
         .i_rstn(I_RSTN),
         .d(div_if[g])
      );
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign O_ROOT_CLK = root_ff;
   assign O_CPU_CLK_EN = cpu_en_ff;
   assign O_FLASH_CLK_EN = cpu_en_ff;
   assign O_SRAM_CLK_EN = cpu_en_ff;
   assign O_PERI_CLK_EN = peri_en_ff;
   assign O_HF_EN = hf_en_ff;
   assign O_LF_CLK = sync2_ff[SRC_LF];
   assign O_WDT_CLK = sync2_ff[SRC_LF];
   assign O_TRIM = trim_ff;
   assign O_MODE = mode_ff;
   assign O_WAKE = wake_ff;
   assign O_CUR_SRC = cur_ff;
   assign O_SWITCHING = busy_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_busy_holds_low: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN) busy_ff |=> !root_ff)
      else $error("root clock moved during changeover");
   a_src_change_low: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN) $changed(cur_ff) |-> !root_ff && $past(busy_ff))
      else $error("source changed outside a held low phase");
   a_active_all_on: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN)
      mode_ff == CPM_ACTIVE |-> cpu_en_ff && peri_en_ff && hf_en_ff)
      else $error("active mode with a gated clock");
   a_sleep_wake_now: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN)
      (mode_ff == CPM_SLEEP) && wake_evt |=> cpu_en_ff && wake_ff)
      else $error("sleep wake did not ungate the CPU at once");
   a_sleep_gates_cpu: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN) mode_ff == CPM_SLEEP |-> !cpu_en_ff && peri_en_ff)
      else $error("sleep gating wrong");
   a_deep_wake_time: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN)
      (mode_ff == CPM_DEEP) && wake_evt |-> ##[1:A_WAKE_LIM] cpu_en_ff)
      else $error("deep sleep wake too slow");
   a_deep_wic_sees: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN)
      (mode_ff == CPM_DEEP) && wake_evt |=> mode_ff == CPM_HFWAKE && hf_en_ff)
      else $error("enabled interrupt missed in deep sleep");
   a_trim_range: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN) trim_ff <= TRIM_MAX)
      else $error("main oscillator trim out of range");
   a_hf_first: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN) $rose(cpu_en_ff) |-> hf_en_ff && $past(hf_en_ff))
      else $error("CPU ungated before high speed clock");
   a_entry_on_req: assert property (@(posedge I_CLK)
      disable iff (!I_RSTN) (mode_ff == CPM_ACTIVE) && !I_SLEEP_REQ
      && !I_DEEP_REQ |=> mode_ff == CPM_ACTIVE)
      else $error("low power entered without request");

endmodule

// ==== verification/cpm_far_model.sv ====
/*
 * Far-side model: the oscillators that feed the controller.
 * Assumes the controller's system clock and its high-speed enable output.
 */
`timescale 1ns/1ps
module cpm_far_model (
   input wire logic i_clk,
   input wire logic i_hf_en,
   output logic o_main_osc,
   output logic o_lf_osc,
   output logic o_watch_osc,
   output logic o_ext_clk
);
   // ------------------------------------------------------------
   // Phase counter and oscillator levels
   // ------------------------------------------------------------
   logic [7:0] cnt = 8'h00;
   logic main_ff = 1'b0;

   // Main osc period is four system cycles; it halts low when disabled
   always @(posedge i_clk) begin
      cnt <= cnt + 8'h01;
      main_ff <= i_hf_en ? cnt[1] : 1'b0;
   end

   // Slow sources never stop, so the watchdog keeps its clock
   assign o_main_osc = main_ff;
   assign o_lf_osc = cnt[4];
   assign o_watch_osc = cnt[5];
   assign o_ext_clk = cnt[2];
endmodule

// ==== verification/tb_clock_and_power_mode_control.sv ====
/*
 * Self-checking bench for the clock and power-mode controller.
 * Assumes the far-side model supplies all four oscillator levels.
 */
`timescale 1ns/1ps
module tb_clock_and_power_mode_control;
   import cpm_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic I_CLK = 1'b0;
   logic I_RSTN = 1'b0;
   logic [1:0] src_sel = 2'h0;
   logic [2:0] trim = 3'h0;
   logic slp = 1'b0;
   logic deep = 1'b0;
   logic [7:0] irq = 8'h00;
   logic [7:0] irq_en = 8'h00;
   logic [7:0] div_en = 8'h00;
   logic [127:0] div_val = '0;
   logic [9:0] div_frac = 10'h000;
   logic mosc, lfo, wosc, eclk, root, cpu, fl, sr, peri, hf, lfc, wdt;
   logic wake, swg;
   logic [2:0] o_trim;
   logic [1:0] mode, cur;
   logic [7:0] tick;
   int err_total = 0;
   int cmp_count = 0;
   logic [31:0] rnd = 32'hddf2_b775;
   int n;
   int v[8];
   int ts[$];
   logic [1:0] lf_q = 2'h0;

   // Half period of 20 ns gives 25 MHz
   always #20 I_CLK = ~I_CLK;

   cpm_far_model u_far (.i_clk(I_CLK), .i_hf_en(hf), .o_main_osc(mosc),
      .o_lf_osc(lfo), .o_watch_osc(wosc), .o_ext_clk(eclk));

   cpm_top u_dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_MAIN_OSC(mosc),
      .I_LF_OSC(lfo), .I_WATCH_OSC(wosc), .I_EXT_CLK(eclk),
      .I_SRC_SEL(src_sel), .I_TRIM_SEL(trim), .I_SLEEP_REQ(slp),
      .I_DEEP_REQ(deep), .I_IRQ(irq), .I_IRQ_EN(irq_en),
      .I_DIV_EN(div_en), .I_DIV_VAL(div_val), .I_DIV_FRAC(div_frac),
      .O_ROOT_CLK(root), .O_CPU_CLK_EN(cpu), .O_FLASH_CLK_EN(fl),
      .O_SRAM_CLK_EN(sr), .O_PERI_CLK_EN(peri), .O_HF_EN(hf),
      .O_LF_CLK(lfc), .O_WDT_CLK(wdt), .O_TRIM(o_trim), .O_MODE(mode),
      .O_WAKE(wake), .O_CUR_SRC(cur), .O_SWITCHING(swg),
      .O_DIV_TICK(tick));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Maximal-length feedback keeps the sequence repeatable
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Settle point: half a cycle after the last rising edge
   task automatic look(input int k);
      repeat (k) @(posedge I_CLK);
      @(negedge I_CLK);
   endtask

   task automatic report_and_stop;
      $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Two-stage copy of the slow oscillator, the same delay as the pins
   always @(posedge I_CLK) begin
      lf_q <= {lf_q[0], lfo};
   end

   // Root must be held low across a changeover; both slow clocks track lf
   always @(negedge I_CLK) begin
      if (I_RSTN && swg === 1'b1) begin
         chk(root, 1'b0);
      end
      if (I_RSTN) begin
         chk({wdt, lfc}, {2{lf_q[1]}});
      end
   end

   // Hang guard, far beyond the expected run length
   initial begin
      repeat (60000) @(posedge I_CLK);
      err_total++;
      report_and_stop();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge I_CLK);
      I_RSTN <= 1'b1;
      look(0);
      chk({mode, o_trim, cpu, fl, sr, peri, hf}, 10'h01f);
      // Trim steps, including the one code above the ceiling
      for (int t = 0; t < 8; t++) begin
         @(posedge I_CLK);
         trim <= t[2:0];
         look(3);
         chk(o_trim, (t > 6) ? 6 : t);
      end
      // Sleep: only the CPU subsystem stops; deep request is ignored there
      @(posedge I_CLK);
      slp <= 1'b1;
      look(2);
      chk({mode, cpu, fl, sr, peri}, 6'h11);
      @(posedge I_CLK);
      slp <= 1'b0;
      deep <= 1'b1;
      rnd = lfsr(rnd);
      irq <= 8'h01 << rnd[2:0];
      look(4);
      chk({mode, hf}, 3'h3);
      @(posedge I_CLK);
      deep <= 1'b0;
      irq_en <= 8'h01 << rnd[2:0];
      // Wake pulse stands only in the cycle after the wake edge
      look(1);
      chk({mode, cpu, fl, sr, peri, wake}, 7'h1f);
      look(1);
      chk(wake, 1'b0);
      // Deep sleep: deep beats sleep; high speed returns before the CPU
      @(posedge I_CLK);
      irq <= 8'h00;
      deep <= 1'b1;
      slp <= 1'b1;
      look(2);
      chk({mode, cpu, peri, hf}, 5'h18);
      @(posedge I_CLK);
      deep <= 1'b0;
      slp <= 1'b0;
      rnd = lfsr(rnd);
      irq <= 8'h01 << rnd[5:3];
      irq_en <= 8'h01 << rnd[5:3];
      n = 0;
      while (hf !== 1'b1 && n < 20) begin
         look(0);
         n++;
      end
      chk({hf, cpu, wake}, 3'h5);
      while (mode !== CPM_ACTIVE && n < 900) begin
         look(0);
         n++;
      end
      chk(n <= WAKE_CYC + 2, 1'b1);
      chk({cpu, peri, hf}, 3'h7);
      @(posedge I_CLK);
      irq <= 8'h00;
      // Every source in turn; selection must cross the synchroniser
      for (int s = 1; s < 5; s++) begin
         @(posedge I_CLK);
         src_sel <= s[1:0];
         look(0);
         chk({cur, swg}, {s[1:0] - 2'h1, 1'b0});
         n = 0;
         while (cur !== s[1:0] && n < 600) begin
            look(0);
            n++;
         end
         chk(cur, s[1:0]);
      end
      // Dividers on the main source, root period four cycles
      for (int g = 0; g < 8; g++) begin
         rnd = lfsr(rnd);
         v[g] = (g == 7) ? 256 : 1 + rnd[1:0];
      end
      @(posedge I_CLK);
      for (int g = 0; g < 8; g++) begin
         div_val[16*g+:16] <= v[g][15:0];
      end
      div_frac <= 10'h210;
      div_en <= 8'hff;
      for (int g = 0; g < 8; g++) begin
         ts.delete();
         n = 0;
         while (ts.size() < 3 && n < 7000) begin
            look(0);
            n++;
            if (tick[g] === 1'b1) begin
               ts.push_back(n);
            end
         end
         // Half fraction adds one root edge every second period
         chk((ts.size() == 3) ? ts[2] - ts[0] : 0,
            8 * (v[g] + 1) + ((g < 2) ? 4 : 0));
      end
      // A disabled divider stays silent
      @(posedge I_CLK);
      div_en <= 8'hf7;
      // A tick launched at the disabling edge may still stand
      look(1);
      n = 0;
      repeat (200) begin
         look(0);
         if (tick[3] !== 1'b0) begin
            n++;
         end
      end
      chk(n, 0);
      report_and_stop();
   end
endmodule
